// ===== usc_defs.svh
// offsets, field positions, reset values and timing counts of the serial status/control block
`ifndef USC_DEFS_SVH
`define USC_DEFS_SVH
`define USC_OFF_STATUS_CONTROL 12'h000
`define USC_OFF_TX_DATA        12'h004
`define USC_OFF_RX_DATA        12'h008
`define USC_OFF_IRQ_STATUS     12'h00C
`define USC_OFF_IRQ_MASK       12'h010
`define USC_OFF_BAUD_DIV       12'h014
`define USC_BIT_TXISEL1        15
`define USC_BIT_TXINV          14
`define USC_BIT_TXISEL0        13
`define USC_BIT_TXBRK          11
`define USC_BIT_TXEN           10
`define USC_BIT_TXBF           9
`define USC_BIT_TX_SHIFT_EMPTY           8
`define USC_BIT_RXISEL1        7
`define USC_BIT_RXISEL0        6
`define USC_BIT_ADDRESS_DETECT_ENABLE          5
`define USC_BIT_RX_LINE_IDLE          4
`define USC_BIT_RX_PARITY_ERROR           3
`define USC_BIT_RX_FRAMING_ERROR           2
`define USC_BIT_RX_OVERRUN_ERROR           1
`define USC_BIT_RXDA           0
`define USC_BIT_IRQ_TX         0
`define USC_BIT_IRQ_RX         1
`define USC_BIT_IRQ_OVR        2
`define USC_RX_DEPTH           3'h4
`define USC_BREAK_ZEROS        4'hC
`define USC_BAUD_DIV_RESET     16'h0364
`define USC_IR_PULSE_DIV       4'h3
`endif

// ===== usc_pkg.sv
// types shared by the serial status/control block
package usc_pkg;
    typedef enum logic [1:0] {USC_TXI_EACH, USC_TXI_DONE, USC_TXI_EMPTY, USC_TXI_RSVD} usc_txi_t;
    typedef enum logic [1:0] {USC_RXI_ANY0, USC_RXI_ANY1, USC_RXI_THREE, USC_RXI_FULL} usc_rxi_t;
endpackage : usc_pkg

// ===== usc_rx_if.sv
// receive path signals between the top and the receiver
`timescale 1ns/1ns
interface usc_rx_if;
    logic       done;
    logic [7:0] data;
    logic       rx_framing_error;
    logic       idle;
    modport rcv (output done, output data, output rx_framing_error, output idle);
    modport top (input done, input data, input rx_framing_error, input idle);
endinterface : usc_rx_if

// ===== usc_rx.sv
// serial receiver: 8N1, 16x oversampling
`timescale 1ns/1ns
`include "usc_defs.svh"
module usc_rx
    import usc_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // timing
    input  wire logic tick16,
    // line, already synchronised
    input  wire logic rx_line,
    // result
    usc_rx_if.rcv     rxo
);
    typedef enum logic [1:0] {USC_R_IDLE, USC_R_START, USC_R_DATA, USC_R_STOP} usc_rst_t;
    usc_rst_t   state, next_state;
    logic [3:0] os, next_os;
    logic [2:0] bitn, next_bitn;
    logic [7:0] sh, next_sh;
    logic       done, next_done, rx_framing_error, next_rx_framing_error;

    always_comb begin
        next_state = state;
        next_os    = os;
        next_bitn  = bitn;
        next_sh    = sh;
        next_done  = 1'b0;
        next_rx_framing_error  = rx_framing_error;
        if (tick16) begin
            next_os = os + 4'h1;
            unique case (state)
                USC_R_IDLE: begin
                    next_os = 4'h0;
                    if (!rx_line) next_state = USC_R_START;
                end
                USC_R_START: if (os == 4'h7) begin
                    next_os    = 4'h0;
                    next_bitn  = 3'h0;
                    next_state = rx_line ? USC_R_IDLE : USC_R_DATA;
                end
                USC_R_DATA: if (os == 4'hF) begin
                    next_sh   = {rx_line, sh[7:1]};
                    next_bitn = bitn + 3'h1;
                    if (bitn == 3'h7) next_state = USC_R_STOP;
                end
                USC_R_STOP: if (os == 4'hF) begin
                    next_done  = 1'b1;
                    next_rx_framing_error  = !rx_line;
                    next_state = USC_R_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= USC_R_IDLE;
            os    <= 4'h0;
            bitn  <= 3'h0;
            sh    <= 8'h00;
            done  <= 1'b0;
            rx_framing_error  <= 1'b0;
        end else begin
            state <= next_state;
            os    <= next_os;
            bitn  <= next_bitn;
            sh    <= next_sh;
            done  <= next_done;
            rx_framing_error  <= next_rx_framing_error;
        end
    end

    assign rxo.done = done;
    assign rxo.data = sh;
    assign rxo.rx_framing_error = rx_framing_error;
    assign rxo.idle = (state == USC_R_IDLE);
endmodule : usc_rx

// ===== usc_top.sv
// serial transceiver status/control with APB registers
// Notes on behaviour
// [R1] tx mode 00: interrupt on each buffer-to-shift-register transfer.
// [R2] tx mode 01: interrupt when the last character fully shifted out.
// [R3] tx mode 10: interrupt when a transfer leaves the transmit buffer empty.
// [R4] software never writes tx mode 11; it is reserved.
// [R5] encoding off: invert bit set idles line low, clear idles high.
// [R6] encoding on: invert bit set gives idle-high, clear idle-low output.
// [R7] break request sends start, twelve zeros, stop on next transmission.
// [R8] hardware clears break request when the break has finished.
// [R9] transmit enable gives pin to transceiver, else to port logic.
// [R10] clearing transmit enable aborts transmission and empties buffer.
// [R11] buffer-full flag reads one when no character can be accepted; with transmit enable clear the code refuses writes yet it reads zero.
// [R12] shift-empty flag reads one only when shifter and buffer are empty.
// [R13] rx mode 11: interrupt when buffer reaches four characters.
// [R14] rx mode 10: interrupt when buffer reaches three characters.
// [R15] rx mode 0x: interrupt on every received character.
// [R16] overrun sets on a character into a full buffer; cleared by writing zero.
// [R17] data-available reads one while the receive buffer holds a character.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "usc_defs.svh"
module usc_top
    import usc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // serial line
    input  wire logic        serial_rx_pin,
    input  wire logic        port_tx_value,
    output logic             serial_tx_pin,
    output logic             serial_tx_oe_n,
    // interrupt
    output logic             irq
);
    // control fields
    logic [1:0]  tx_irq_mode, rx_irq_mode;
    logic        tx_polarity_invert, tx_break_request, tx_enable_bit;
    logic        address_detect_enable, infrared_encode_enable;
    logic        rx_parity_error, rx_overrun_error;
    logic [15:0] baud_div;
    logic [2:0]  irq_mask, irq_status;
    // transmit buffer (one character) and shifter
    logic [7:0]  tx_buf;
    logic        tx_buf_full;
    logic [9:0]  tx_shift_register;
    logic [3:0]  tx_bits;
    logic        tx_busy, tx_brk_frame;
    logic [3:0]  tx_os;
    // receive buffer
    logic [7:0]  rx_mem [0:3];
    logic [1:0]  rx_wp, rx_rp;
    logic [2:0]  rx_cnt;
    // baud divider
    logic [15:0] bcnt;
    logic        tick16;
    logic        rx_s1, rx_s2;
    logic        tx_raw, ir_out, line_out;

    logic [1:0]  next_tx_irq_mode, next_rx_irq_mode;
    logic        next_tx_polarity_invert, next_tx_break_request, next_tx_enable_bit;
    logic        next_address_detect_enable, next_infrared_encode_enable, next_rx_overrun_error;
    logic [15:0] next_baud_div;
    logic [2:0]  next_irq_mask, next_irq_status;
    logic [7:0]  next_tx_buf;
    logic        next_tx_buf_full;
    logic [9:0]  next_tx_shift;
    logic [3:0]  next_tx_bits, next_tx_os;
    logic        next_tx_busy, next_tx_brk_frame;
    logic [1:0]  next_rx_wp, next_rx_rp;
    logic [2:0]  next_rx_cnt;
    logic [31:0] next_prdata;
    logic        next_pready, next_pslverr, next_irq, next_pin, next_oe_n;
    logic        ev_tx, ev_rx, ev_ovr, wr, rd, load, push, pop;

    usc_rx_if rxi ();
    usc_rx u_rx (.clk_sys(clk_sys), .rst(rst), .tick16(tick16), .rx_line(rx_s2), .rxo(rxi));

    function automatic logic acc_hit(input logic [11:0] a, input logic [11:0] off);
        acc_hit = (a == off);
    endfunction : acc_hit

    function automatic logic [15:0] status_word(input logic dummy);
        status_word = {tx_irq_mode[1], tx_polarity_invert, tx_irq_mode[0], 1'b0,
                       tx_break_request, tx_enable_bit,
                       tx_buf_full,                                       // R11
                       !tx_buf_full && !tx_busy,                          // R12
                       rx_irq_mode, address_detect_enable, rxi.idle, rx_parity_error,
                       rxi.rx_framing_error, rx_overrun_error,
                       rx_cnt != 3'h0};                                   // R17
    endfunction : status_word

    assign wr   = psel && penable && pready && pwrite;
    assign rd   = psel && penable && pready && !pwrite;
    assign load = tx_buf_full && !tx_busy && tick16 && tx_enable_bit;
    assign push = rxi.done && rx_cnt != `USC_RX_DEPTH;
    assign pop  = rd && acc_hit(paddr, `USC_OFF_RX_DATA) && rx_cnt != 3'h0;

    // serial output: shifter bit or idle level, then optional pulse encoding
    assign tx_raw   = tx_busy ? tx_shift_register[0] : 1'b1;
    assign ir_out   = !tx_raw && tx_os < `USC_IR_PULSE_DIV;
    assign line_out = infrared_encode_enable ? (ir_out ^ tx_polarity_invert)   // R6
                                             : (tx_raw ^ tx_polarity_invert);  // R5

    always_comb begin
        next_tx_irq_mode            = tx_irq_mode;
        next_rx_irq_mode            = rx_irq_mode;
        next_tx_polarity_invert     = tx_polarity_invert;
        next_tx_break_request       = tx_break_request;
        next_tx_enable_bit          = tx_enable_bit;
        next_address_detect_enable  = address_detect_enable;
        next_infrared_encode_enable = infrared_encode_enable;
        next_rx_overrun_error       = rx_overrun_error;
        next_baud_div               = baud_div;
        next_irq_mask               = irq_mask;
        next_tx_buf                 = tx_buf;
        next_tx_buf_full            = tx_buf_full;
        next_tx_shift               = tx_shift_register;
        next_tx_bits                = tx_bits;
        next_tx_os                  = tx_os;
        next_tx_busy                = tx_busy;
        next_tx_brk_frame           = tx_brk_frame;
        next_rx_wp                  = rx_wp;
        next_rx_rp                  = rx_rp;
        next_rx_cnt                 = rx_cnt;
        ev_tx                       = 1'b0;
        ev_ovr                      = rxi.done && rx_cnt == `USC_RX_DEPTH;
        ev_rx                       = 1'b0;
        if (wr) begin
            if (acc_hit(paddr, `USC_OFF_STATUS_CONTROL)) begin
                next_tx_irq_mode           = {pwdata[`USC_BIT_TXISEL1], pwdata[`USC_BIT_TXISEL0]};
                next_tx_polarity_invert    = pwdata[`USC_BIT_TXINV];
                next_tx_break_request      = tx_break_request | pwdata[`USC_BIT_TXBRK];
                next_tx_enable_bit         = pwdata[`USC_BIT_TXEN];
                next_rx_irq_mode           = pwdata[`USC_BIT_RXISEL1:`USC_BIT_RXISEL0];
                next_address_detect_enable = pwdata[`USC_BIT_ADDRESS_DETECT_ENABLE];
                if (!pwdata[`USC_BIT_RX_OVERRUN_ERROR]) next_rx_overrun_error = 1'b0;         // R16
                next_infrared_encode_enable = pwdata[16];
            end
            if (acc_hit(paddr, `USC_OFF_TX_DATA) && !tx_buf_full && tx_enable_bit) begin
                next_tx_buf      = pwdata[7:0];
                next_tx_buf_full = 1'b1;
            end
            if (acc_hit(paddr, `USC_OFF_IRQ_MASK)) next_irq_mask = pwdata[2:0];
            if (acc_hit(paddr, `USC_OFF_BAUD_DIV)) next_baud_div = pwdata[15:0];
        end
        if (ev_ovr) next_rx_overrun_error = 1'b1;                                  // R16
        // transmit shifter
        if (tick16 && tx_busy) begin
            next_tx_os = tx_os + 4'h1;
            if (tx_os == 4'hF) begin
                next_tx_shift = {1'b1, tx_shift_register[9:1]};
                next_tx_bits  = tx_bits - 4'h1;
                if (tx_bits == 4'h1) begin
                    next_tx_busy = 1'b0;
                    if (tx_brk_frame) next_tx_break_request = 1'b0;               // R8
                    if (tx_irq_mode == USC_TXI_DONE && !tx_buf_full) ev_tx = 1'b1; // R2
                end else if (tx_brk_frame && tx_bits > 4'h2) begin
                    next_tx_shift[0] = 1'b0;                                       // R7
                end
            end
        end
        if (load) begin
            next_tx_busy      = 1'b1;
            next_tx_os        = 4'h0;
            next_tx_buf_full  = 1'b0;
            next_tx_brk_frame = tx_break_request;
            // break: start + twelve zeros + stop, else start + 8 data + stop
            next_tx_shift = tx_break_request ? 10'h200 : {1'b1, tx_buf, 1'b0};     // R7
            next_tx_bits  = tx_break_request ? `USC_BREAK_ZEROS + 4'h2 : 4'hA;
            if (tx_irq_mode == USC_TXI_EACH) ev_tx = 1'b1;                         // R1
            if (tx_irq_mode == USC_TXI_EMPTY) ev_tx = 1'b1;                        // R3
        end
        if (!next_tx_enable_bit) begin
            next_tx_busy     = 1'b0;                                               // R10
            next_tx_buf_full = 1'b0;                                               // R10
        end
        // receive buffer
        if (push) begin
            next_rx_wp = rx_wp + 2'h1;
            unique case (rx_irq_mode)
                USC_RXI_FULL:  ev_rx = (rx_cnt == 3'h3);                           // R13
                USC_RXI_THREE: ev_rx = (rx_cnt == 3'h2);                           // R14
                default:       ev_rx = 1'b1;                                       // R15
            endcase
        end
        if (pop) next_rx_rp = rx_rp + 2'h1;
        next_rx_cnt = rx_cnt + {2'h0, push} - {2'h0, pop};
        // interrupt status: read clears, new event wins
        next_irq_status = irq_status;
        // clear only what the read reported, so a later event survives
        if (rd && acc_hit(paddr, `USC_OFF_IRQ_STATUS)) next_irq_status = irq_status & ~prdata[2:0];
        next_irq_status = next_irq_status | {ev_ovr, ev_rx, ev_tx};
        next_irq        = |(next_irq_status & next_irq_mask);
        // apb answer, no wait state
        next_pready  = psel && !penable;
        next_pslverr = 1'b0;
        next_prdata  = 32'h0;
        if (psel && !penable) begin
            unique case (paddr)
                `USC_OFF_STATUS_CONTROL: next_prdata = {15'h0, infrared_encode_enable, status_word(1'b0)};
                `USC_OFF_RX_DATA:        next_prdata = {24'h0, rx_mem[rx_rp]};
                `USC_OFF_IRQ_STATUS:     next_prdata = {29'h0, irq_status};
                `USC_OFF_IRQ_MASK:       next_prdata = {29'h0, irq_mask};
                `USC_OFF_BAUD_DIV:       next_prdata = {16'h0, baud_div};
                `USC_OFF_TX_DATA:        next_prdata = {24'h0, tx_buf};
                default:                 next_pslverr = 1'b1;
            endcase
        end
        next_pin  = tx_enable_bit ? line_out : port_tx_value;                      // R9
        next_oe_n = 1'b0;
    end

    always_ff @(posedge clk_sys) begin
        if (push) rx_mem[rx_wp] <= rxi.data;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_irq_mode            <= 2'h0;
            rx_irq_mode            <= 2'h0;
            tx_polarity_invert     <= 1'b0;
            tx_break_request       <= 1'b0;
            tx_enable_bit          <= 1'b0;
            address_detect_enable  <= 1'b0;
            infrared_encode_enable <= 1'b0;
            rx_parity_error        <= 1'b0;
            rx_overrun_error       <= 1'b0;
            baud_div               <= `USC_BAUD_DIV_RESET;
            irq_mask               <= 3'h0;
            irq_status             <= 3'h0;
            tx_buf                 <= 8'h00;
            tx_buf_full            <= 1'b0;
            tx_shift_register      <= 10'h3FF;
            tx_bits                <= 4'h0;
            tx_os                  <= 4'h0;
            tx_busy                <= 1'b0;
            tx_brk_frame           <= 1'b0;
            rx_wp                  <= 2'h0;
            rx_rp                  <= 2'h0;
            rx_cnt                 <= 3'h0;
            bcnt                   <= 16'h0;
            tick16                 <= 1'b0;
            rx_s1                  <= 1'b1;
            rx_s2                  <= 1'b1;
            prdata                 <= 32'h0;
            pready                 <= 1'b0;
            pslverr                <= 1'b0;
            irq                    <= 1'b0;
            serial_tx_pin          <= 1'b1;
            serial_tx_oe_n         <= 1'b0;
        end else begin
            tx_irq_mode            <= next_tx_irq_mode;
            rx_irq_mode            <= next_rx_irq_mode;
            tx_polarity_invert     <= next_tx_polarity_invert;
            tx_break_request       <= next_tx_break_request;
            tx_enable_bit          <= next_tx_enable_bit;
            address_detect_enable  <= next_address_detect_enable;
            infrared_encode_enable <= next_infrared_encode_enable;
            rx_overrun_error       <= next_rx_overrun_error;
            baud_div               <= next_baud_div;
            irq_mask               <= next_irq_mask;
            irq_status             <= next_irq_status;
            tx_buf                 <= next_tx_buf;
            tx_buf_full            <= next_tx_buf_full;
            tx_shift_register      <= next_tx_shift;
            tx_bits                <= next_tx_bits;
            tx_os                  <= next_tx_os;
            tx_busy                <= next_tx_busy;
            tx_brk_frame           <= next_tx_brk_frame;
            rx_wp                  <= next_rx_wp;
            rx_rp                  <= next_rx_rp;
            rx_cnt                 <= next_rx_cnt;
            bcnt                   <= (bcnt >= baud_div) ? 16'h0 : bcnt + 16'h1;
            tick16                 <= (bcnt >= baud_div);
            rx_s1                  <= serial_rx_pin;
            rx_s2                  <= rx_s1;
            prdata                 <= next_prdata;
            pready                 <= next_pready;
            pslverr                <= next_pslverr;
            irq                    <= next_irq;
            serial_tx_pin          <= next_pin;
            serial_tx_oe_n         <= next_oe_n;
        end
    end

    // assertions
    sequence load_seq;
        load && tx_irq_mode == USC_TXI_EACH;
    endsequence
    tx_each_irq_a: assert property (@(posedge clk_sys) disable iff (rst)       // R1
        load_seq |=> irq_status[`USC_BIT_IRQ_TX]) else $error("tx mode 00 event missing");
    tx_done_irq_a: assert property (@(posedge clk_sys) disable iff (rst)       // R2
        $past(tx_irq_mode) == USC_TXI_DONE && $rose(irq_status[`USC_BIT_IRQ_TX])
        |-> $past(tx_busy) && !tx_busy && !$past(tx_buf_full))
        else $error("tx mode 01 event while busy");
    tx_empty_irq_a: assert property (@(posedge clk_sys) disable iff (rst)      // R3
        load && tx_irq_mode == USC_TXI_EMPTY |=> irq_status[0] && !tx_buf_full)
        else $error("tx mode 10 event missing");
    pol_plain_a: assert property (@(posedge clk_sys) disable iff (rst)         // R5
        tx_enable_bit && !infrared_encode_enable && !tx_busy |=> serial_tx_pin == !$past(tx_polarity_invert))
        else $error("idle level wrong");
    brk_clear_a: assert property (@(posedge clk_sys) disable iff (rst)         // R8
        $fell(tx_break_request) && tx_enable_bit |-> $past(tx_brk_frame) && !tx_busy)
        else $error("break cleared early");
    pin_owner_a: assert property (@(posedge clk_sys) disable iff (rst)         // R9
        !tx_enable_bit |=> serial_tx_pin == $past(port_tx_value)) else $error("pin not given to port");
    abort_a: assert property (@(posedge clk_sys) disable iff (rst)             // R10
        !tx_enable_bit |-> !tx_busy && !tx_buf_full) else $error("abort incomplete");
    rx_full_irq_a: assert property (@(posedge clk_sys) disable iff (rst)       // R13
        push && !pop && rx_irq_mode == USC_RXI_FULL && rx_cnt == 3'h3 |=> irq_status[1] && rx_cnt == 3'h4)
        else $error("rx full event missing");
    rx_three_irq_a: assert property (@(posedge clk_sys) disable iff (rst)      // R14
        push && rx_irq_mode == USC_RXI_THREE && rx_cnt != 3'h2 && !irq_status[1] |=> !irq_status[1])
        else $error("rx three event spurious");
    overrun_a: assert property (@(posedge clk_sys) disable iff (rst)           // R16
        rxi.done && rx_cnt == 3'h4 |=> rx_overrun_error) else $error("overrun not flagged");
endmodule : usc_top

// ===== usc_far.sv
// remote transmitter model driving the receive line
`timescale 1ns/1ns
module usc_far #(
    parameter int BIT_CLKS = 16
) (
    // clock
    input  wire logic clk_sys,
    // line toward the device, idles high
    output logic      line
);
    initial line = 1'b1;
    // 8N1, lsb first, start low, stop high
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys);
            line <= f[i];
            repeat (BIT_CLKS - 1) @(posedge clk_sys);
        end
    endtask : send
endmodule : usc_far

// ===== uart_tx_rx_status_control_bench.sv
// self-checking bench for the serial status/control block
`timescale 1ns/1ns
module uart_tx_rx_status_control_bench
    import usc_pkg::*;
;
    localparam logic [11:0] SC = 12'h000, TXD = 12'h004, RXD = 12'h008;
    localparam logic [11:0] IST = 12'h00C, IMK = 12'h010, BD = 12'h014;
    logic        clk_sys, rst, psel, penable, pwrite, port_tx_value, err;
    logic        pready, pslverr, serial_rx_pin, serial_tx_pin, serial_tx_oe_n, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          mismatches = 0, checks_done = 0, run = 0, maxrun = 0;
    logic [31:0] pin_ctl [5] = '{32'h0, 32'h400, 32'h4400, 32'h14400, 32'h10400};
    logic [31:0] pin_exp [5] = '{32'h0, 32'h1, 32'h0, 32'h1, 32'h0};
    logic [7:0]  rx_bytes [5] = '{8'h11, 8'h22, 8'h5A, 8'hC3, 8'hEE};
    logic [31:0] rx_irq [5] = '{32'h0, 32'h0, 32'h2, 32'h2, 32'h4};

    usc_top u_dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .serial_rx_pin, .port_tx_value, .serial_tx_pin, .serial_tx_oe_n, .irq);
    usc_far u_far (.clk_sys(clk_sys), .line(serial_rx_pin));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // longest low stretch on the transmit pin
    always @(posedge clk_sys) begin
        run = serial_tx_pin ? 0 : run + 1;
        if (run > maxrun) maxrun = run;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            wrap_up;
        end else begin
            rd = prdata;
            err = pslverr;
            {psel, penable} <= 2'b00;
        end
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd & m);
    endtask : rdchk

    initial begin
        {psel, penable, pwrite, port_tx_value, paddr, pwdata} = '0;
        rst = 1'b1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rdchk("status reset", SC, 32'hFFFF, 32'h0110);
        rdchk("baud reset", BD, 32'hFFFF, 32'h0364);
        apb(1'b0, 12'h018, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        wr(BD, 32'h0);
        wr(IMK, 32'h7);
        foreach (pin_ctl[i]) begin
            wr(SC, pin_ctl[i]);
            repeat (3) @(posedge clk_sys);
            chk("idle pin", pin_exp[i], {31'h0, serial_tx_pin});
        end
        chk("oe_n", 32'h0, {31'h0, serial_tx_oe_n});
        wr(SC, 32'h0);
        port_tx_value <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("port pin", 32'h1, {31'h0, serial_tx_pin});
        // mode loop stops short of the reserved encoding
        for (int m = 0; m < 3; m++) begin
            wr(SC, {16'h0, m[1], 1'b0, m[0], 13'h0400});
            apb(1'b0, IST, 32'h0);
            wr(TXD, 32'hA5);
            repeat (20) @(posedge clk_sys);
            chk("irq pin", {31'h0, m != 1}, {31'h0, irq});
            rdchk("tx irq early", IST, 32'h1, {31'h0, m != 1});
            repeat (200) @(posedge clk_sys);
            rdchk("tx irq late", IST, 32'h1, {31'h0, m == 1});
        end
        wr(TXD, 32'h0);
        wr(TXD, 32'h0);
        rdchk("full busy", SC, 32'h300, 32'h200);
        wr(SC, 32'h0);
        rdchk("aborted", SC, 32'h300, 32'h100);
        wr(IMK, 32'h0);
        wr(SC, 32'h0C00);
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys) {run, maxrun} = '0;
        wr(TXD, 32'hFF);
        repeat (400) @(posedge clk_sys);
        chk("break low", 32'd208, maxrun);
        rdchk("break done", SC, 32'h800, 32'h0);
        chk("masked irq", 32'h0, {31'h0, irq});
        wr(IMK, 32'h7);
        @(posedge clk_sys);
        chk("unmasked irq", 32'h1, {31'h0, irq});
        apb(1'b0, IST, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk("cleared irq", 32'h0, {31'h0, irq});
        wr(SC, 32'h0080);
        apb(1'b0, IST, 32'h0);
        for (int i = 0; i < 5; i++) begin
            if (i == 3) wr(SC, 32'h00C0);
            u_far.send(rx_bytes[i]);
            repeat (20) @(posedge clk_sys);
            rdchk("rx irq", IST, 32'h6, rx_irq[i]);
        end
        rdchk("rx flags", SC, 32'h3, 32'h3);
        wr(SC, 32'h00C0);
        rdchk("overrun clear", SC, 32'h2, 32'h0);
        for (int i = 0; i < 4; i++) rdchk("rx data", RXD, 32'hFF, {24'h0, rx_bytes[i]});
        rdchk("rx empty", SC, 32'h1, 32'h0);
        for (int m = 0; m < 2; m++) begin
            wr(SC, {24'h0, 1'b0, m[0], 6'h0});
            u_far.send(8'h3C);
            repeat (20) @(posedge clk_sys);
            rdchk("rx any", IST, 32'h2, 32'h2);
            apb(1'b0, RXD, 32'h0);
        end
        wrap_up;
    end
endmodule : uart_tx_rx_status_control_bench
